// *** src/fpp_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fpp_regs.svh"
module fpp_port (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// power manager
	input  wire logic        standby_req,
	// shared peripherals
	input  wire logic [4:0]  periph_oe,
	input  wire logic [4:0]  periph_out,
	output logic [4:0]       periph_in,
	// pads
	input  wire logic [4:0]  pin_in,
	output logic [4:0]       pin_out,
	output logic [4:0]       pin_oe,
	output logic [4:0]       pullup_en
);
	fpp_reg_if          rif ();
	fpp_pkg::fpp_state_t st_q;
	fpp_pkg::fpp_state_t st_d;
	logic               float_all;
	logic [4:0]         keep_in;
	logic [4:0]         port_out;
	logic [4:0]         rd_pins;
	logic [7:0]         rd_mux;

	localparam logic [4:0] OD_MASK   = `FPP_OD_MASK;
	localparam logic [4:0] PULL_MASK = `FPP_PULL_MASK;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	fpp_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rif       (rif)
	);

	// float only while the chip sits in stop or watch mode
	assign float_all = standby_req & st_q.float_en;

	// wake-capable inputs bypass the standby input gate
	always_comb begin
		keep_in = 5'h00;
		keep_in[`FPP_PIN_SDI]  = st_q.irq_en & st_q.sel_zero;
		keep_in[`FPP_PIN_TRIG] = st_q.irq_en & st_q.sel_three;
	end

	for (genvar i = 0; i < fpp_pkg::PINS; i++) begin : g_pin
		fpp_pin_mux #(
			.OPEN_DRAIN (OD_MASK[i]),
			.HAS_PULL   (PULL_MASK[i])
		) u_mux (
			.latch      (st_q.latch[i]),
			.dir        (st_q.dir[i]),
			.pu         (st_q.pu[i]),
			.float_all  (float_all),
			.keep_in    (keep_in[i]),
			.periph_oe  (periph_oe[i]),
			.periph_out (periph_out[i]),
			.periph_in  (periph_in[i]),
			.pin_in     (pin_in[i]),
			.pin_out    (port_out[i]),
			.pin_oe     (pin_oe[i]),
			.pullup_en  (pullup_en[i])
		);
	end
	assign pin_out = port_out;

	function automatic logic [4:0] port_view(
		input logic [4:0] latch,
		input logic [4:0] dir,
		input logic [4:0] poe,
		input logic [4:0] sensed
	);
		// plain port outputs read back the latch, all else the pad
		port_view = (latch & dir & ~poe) | (sensed & ~(dir & ~poe));
	endfunction

	// sensed level is the gated one, so a floated non-output pin reads low unless kept as a wake input
	assign rd_pins = port_view(st_q.latch, st_q.dir, periph_oe, periph_in);

	always_comb begin
		rd_mux = 8'h00;
		unique case (rif.idx)
			`FPP_IDX_LATCH:     rd_mux = {3'h0, rd_pins};
			`FPP_IDX_LATCH_RMW: rd_mux = {3'h0, st_q.latch};
			`FPP_IDX_DIR:       rd_mux = {3'h0, st_q.dir};
			`FPP_IDX_PULLUP:    rd_mux = {3'h0, st_q.pu};
			`FPP_IDX_STANDBY:   rd_mux[`FPP_FLOAT_BIT] = st_q.float_en;
			`FPP_IDX_IRQ_CFG: begin
				rd_mux[`FPP_IRQ_EN_BIT]    = st_q.irq_en;
				rd_mux[`FPP_SEL_ZERO_BIT]  = st_q.sel_zero;
				rd_mux[`FPP_SEL_THREE_BIT] = st_q.sel_three;
			end
			default:            rd_mux = 8'h00;
		endcase
	end
	assign rif.rdata = rd_mux;

	always_comb begin
		st_d = st_q;
		if (rif.wr_en) begin
			unique case (rif.idx)
				`FPP_IDX_LATCH:   st_d.latch = rif.wdata[4:0];
				`FPP_IDX_DIR:     st_d.dir = rif.wdata[4:0];
				`FPP_IDX_PULLUP:  st_d.pu = rif.wdata[4:0];
				`FPP_IDX_STANDBY: st_d.float_en = rif.wdata[`FPP_FLOAT_BIT];
				`FPP_IDX_IRQ_CFG: begin
					st_d.irq_en    = rif.wdata[`FPP_IRQ_EN_BIT];
					st_d.sel_zero  = rif.wdata[`FPP_SEL_ZERO_BIT];
					st_d.sel_three = rif.wdata[`FPP_SEL_THREE_BIT];
				end
				default: st_d = st_q;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= '0;
			st_q.latch <= `FPP_RST_LATCH;
			st_q.dir   <= `FPP_RST_DIR;
			st_q.pu    <= `FPP_RST_PULLUP;
		end else begin
			st_q <= st_d;
		end
	end

	sequence s_latch_write;
		rif.wr_en && rif.idx == `FPP_IDX_LATCH;
	endsequence

	sequence s_latch_read;
		rif.rd_en && rif.idx == `FPP_IDX_LATCH;
	endsequence

	a_out_latch: assert property (
		((st_q.dir & ~periph_oe & (pin_out ^ st_q.latch)) == 5'h00) &&
		(float_all || ((st_q.dir & ~periph_oe & ~`FPP_OD_MASK & ~pin_oe) == 5'h00))
	) else $error("output pin not driven from latch");

	a_write_pins: assert property (
		s_latch_write |=> st_q.latch == $past(rif.wdata[4:0]) &&
			((st_q.dir & ~periph_oe & (pin_out ^ $past(rif.wdata[4:0]))) == 5'h00)
	) else $error("latch write did not reach output pins");

	a_read_output: assert property (
		s_latch_read |-> ((rif.rdata[4:0] ^ st_q.latch) & st_q.dir & ~periph_oe) == 5'h00
	) else $error("output pin read did not return latch");

	a_input_hiz: assert property (
		(pin_oe & ~st_q.dir & ~periph_oe) == 5'h00
	) else $error("input pin is driven");

	a_rmw_view: assert property (
		rif.rd_en && rif.idx == `FPP_IDX_LATCH_RMW |-> rif.rdata == {3'h0, st_q.latch}
	) else $error("rmw read did not return latch");

	a_read_pad: assert property (
		s_latch_read |-> ((rif.rdata[4:0] ^ periph_in) & (periph_oe | ~st_q.dir)) == 5'h00
	) else $error("pad level not returned on read");

	a_read_hrdata: assert property (
		s_latch_read ##1 hreadyout |->
			hrdata[4:0] == $past(rd_pins) && hrdata[31:5] == 27'h0
	) else $error("bus read data does not match port view");

	a_reset_dir: assert property (
		$rose(hresetn) |-> st_q.dir == 5'h00
	) else $error("direction not cleared by reset");

	a_float_hiz: assert property (
		float_all |-> pin_oe == 5'h00 && (periph_in & ~keep_in) == 5'h00
	) else $error("standby float did not release and gate pins");

	a_wake_input: assert property (
		float_all && st_q.irq_en && st_q.sel_zero |->
			periph_in[`FPP_PIN_SDI] == pin_in[`FPP_PIN_SDI]
	) else $error("wake input gated in standby");

	a_hold_config: assert property (
		!st_q.float_en && $rose(standby_req) |-> $stable(pin_oe) && $stable(pin_out)
	) else $error("pins changed on standby entry");

	a_pull_on: assert property (
		(~pin_oe & st_q.pu & `FPP_PULL_MASK & ~pullup_en) == 5'h00
	) else $error("pull-up not connected");

	a_pull_low: assert property (
		(pullup_en & pin_oe & ~pin_out) == 5'h00
	) else $error("pull-up on while driving low");

	a_od_release: assert property (
		(`FPP_OD_MASK & pin_oe & pin_out) == 5'h00
	) else $error("open-drain pin driven high");

	a_dbg_pull: assert property (
		pullup_en[2] == 1'b0
	) else $error("debug pin pull-up enabled");

	a_upper_zero: assert property (
		rif.rd_en |-> rif.rdata[7:5] == 3'h0
	) else $error("unimplemented bits read nonzero");

	sequence s_bus_read;
		hsel && htrans[1] && hready && !hwrite;
	endsequence

	sequence s_bus_write;
		hsel && htrans[1] && hready && hwrite;
	endsequence

	sequence s_read_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	sequence s_rmw_read;
		rif.rd_en && rif.idx == `FPP_IDX_LATCH_RMW;
	endsequence

	a_read_stall: assert property (
		s_bus_read |=> s_read_answer
	) else $error("read did not answer after one wait state");

	a_write_no_wait: assert property (
		s_bus_write |=> hreadyout && rif.wr_en
	) else $error("write data phase stalled or lost");

	a_rmw_hrdata: assert property (
		s_rmw_read ##1 hreadyout |-> hrdata == {27'h0, $past(st_q.latch)}
	) else $error("rmw bus read did not return latch");

	a_dir_write: assert property (
		rif.wr_en && rif.idx == `FPP_IDX_DIR |=> st_q.dir == $past(rif.wdata[4:0])
	) else $error("direction write not stored");

	a_pull_write: assert property (
		rif.wr_en && rif.idx == `FPP_IDX_PULLUP |=> st_q.pu == $past(rif.wdata[4:0])
	) else $error("pull-up write not stored");

	a_no_store: assert property (
		rif.wr_en && rif.idx >= `FPP_IDX_LATCH_RMW |=> $stable(st_q)
	) else $error("write to read-only or unmapped index changed state");

	a_input_pass: assert property (
		!float_all |-> periph_in == pin_in
	) else $error("pad level not passed to peripherals");

	a_periph_drive: assert property (
		float_all || ((periph_oe & ~OD_MASK & (~pin_oe | (pin_out ^ periph_out))) == 5'h00)
	) else $error("peripheral output not driven");

	a_wake_trigger: assert property (
		float_all && st_q.irq_en && st_q.sel_three |->
			periph_in[`FPP_PIN_TRIG] == pin_in[`FPP_PIN_TRIG]
	) else $error("trigger wake input gated in standby");

	a_gate_other: assert property (
		float_all |-> (periph_in & 5'h16) == 5'h00
	) else $error("non-wake pin input not gated");

	a_keep_level: assert property (
		standby_req && !float_all && $stable(st_q) && $stable(periph_oe) &&
			$stable(periph_out) |-> $stable(pin_oe) && $stable(pin_out)
	) else $error("pins changed in standby without float");
endmodule
`default_nettype wire

// *** inc/fpp_regs.svh ***
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
// word offsets (byte address = index * 4)
`define FPP_IDX_LATCH     6'h00
`define FPP_IDX_DIR       6'h01
`define FPP_IDX_PULLUP    6'h02
`define FPP_IDX_STANDBY   6'h03
`define FPP_IDX_IRQ_CFG   6'h04
`define FPP_IDX_LATCH_RMW 6'h05
// field positions
`define FPP_FLOAT_BIT     0
`define FPP_IRQ_EN_BIT    0
`define FPP_SEL_ZERO_BIT  1
`define FPP_SEL_THREE_BIT 2
// reset values
`define FPP_RST_LATCH     5'h00
`define FPP_RST_DIR       5'h00
`define FPP_RST_PULLUP    5'h00
// pin roles
`define FPP_PULL_MASK     5'h1b
`define FPP_OD_MASK       5'h02
`define FPP_PIN_SDI       0
`define FPP_PIN_TRIG      3
// read latency of the bus slave in wait states
`define FPP_RD_WAIT       1
`endif

// *** inc/fpp_pkg.sv ***
package fpp_pkg;
	localparam int PINS = 5;

	typedef enum logic [1:0] {
		FPP_IDLE    = 2'b00,
		FPP_WRITE   = 2'b01,
		FPP_RD_WAIT = 2'b11,
		FPP_RD_DATA = 2'b10
	} fpp_phase_t;

	typedef struct packed {
		fpp_phase_t  phase;
		logic [5:0]  idx;
		logic [31:0] rdata;
	} fpp_slv_t;

	typedef struct packed {
		logic [4:0] latch;
		logic [4:0] dir;
		logic [4:0] pu;
		logic       float_en;
		logic       irq_en;
		logic       sel_zero;
		logic       sel_three;
	} fpp_state_t;
endpackage

// *** inc/fpp_reg_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface fpp_reg_if;
	logic       wr_en;
	logic       rd_en;
	logic [5:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport slave (output wr_en, output rd_en, output idx, output wdata, input rdata);
	modport regs  (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// *** src/fpp_ahb_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpp_ahb_slave (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave side
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// register side
	fpp_reg_if.slave         rif
);
	fpp_pkg::fpp_slv_t s_q;
	fpp_pkg::fpp_slv_t s_d;
	logic              take;

	// only word transfers are issued, so hsize is not decoded
	assign take      = hsel & htrans[1] & hready;
	assign hreadyout = (s_q.phase != fpp_pkg::FPP_RD_WAIT);
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;

	assign rif.idx   = s_q.idx;
	assign rif.wdata = hwdata[7:0];
	assign rif.wr_en = (s_q.phase == fpp_pkg::FPP_WRITE);
	// read sampled one cycle late so a write just before it is already visible
	assign rif.rd_en = (s_q.phase == fpp_pkg::FPP_RD_WAIT);

	always_comb begin
		s_d = s_q;
		unique case (s_q.phase)
			fpp_pkg::FPP_RD_WAIT: begin
				s_d.rdata = {24'h000000, rif.rdata};
				s_d.phase = fpp_pkg::FPP_RD_DATA;
			end
			fpp_pkg::FPP_IDLE, fpp_pkg::FPP_WRITE, fpp_pkg::FPP_RD_DATA: begin
				s_d.phase = fpp_pkg::FPP_IDLE;
				if (take) begin
					// unmapped upper addresses fold to an index with no register
					s_d.idx   = (haddr[31:8] == 24'h000000) ? haddr[7:2] : 6'h3f;
					s_d.phase = hwrite ? fpp_pkg::FPP_WRITE : fpp_pkg::FPP_RD_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// *** src/fpp_pin_mux.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpp_pin_mux #(
	parameter logic OPEN_DRAIN = 1'b0,
	parameter logic HAS_PULL   = 1'b1
) (
	// port configuration
	input  wire logic latch,
	input  wire logic dir,
	input  wire logic pu,
	input  wire logic float_all,
	input  wire logic keep_in,
	// peripheral
	input  wire logic periph_oe,
	input  wire logic periph_out,
	output logic      periph_in,
	// pad
	input  wire logic pin_in,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_en
);
	logic value;
	logic drive;

	assign value = periph_oe ? periph_out : latch;
	// open drain releases the pin for a high level
	assign drive = (dir | periph_oe) & ~(OPEN_DRAIN & value);
	assign pin_out = value;
	assign pin_oe  = drive & ~float_all;
	// input gate avoids leakage from a floating pad in standby
	assign periph_in = pin_in & (~float_all | keep_in);
	assign pullup_en = pu & HAS_PULL & ~(pin_oe & ~value);
endmodule
`default_nettype wire

// *** test/fpp_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpp_board (
	// clock
	input  wire logic       hclk,
	// pads from the port
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	input  wire logic [4:0] pullup_en,
	// board drivers
	input  wire logic [4:0] ext_oe,
	input  wire logic [4:0] ext_val,
	output logic [4:0]      pin_in
);
	logic [4:0] alt_q = 5'h00;
	// a floating pad wanders so a stale level never passes
	always @(posedge hclk) begin
		alt_q <= ~alt_q;
	end
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] :
				pullup_en[i] ? 1'b1 : alt_q[i];
		end
	end
endmodule
`default_nettype wire

// *** test/tb_fpp_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fpp_regs.svh"
module tb_fpp_port;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        standby_req;
	logic [4:0]  periph_oe;
	logic [4:0]  periph_out;
	logic [4:0]  periph_in;
	logic [4:0]  pin_in;
	logic [4:0]  pin_out;
	logic [4:0]  pin_oe;
	logic [4:0]  pullup_en;
	logic [4:0]  ext_oe;
	logic [4:0]  ext_val;
	logic [31:0] rd_q;
	int          n_errors;
	int          checks;
	int          cycles;

	assign hready = hreadyout;

	fpp_port fpp_port_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.standby_req(standby_req), .periph_oe(periph_oe),
		.periph_out(periph_out), .periph_in(periph_in), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en)
	);

	fpp_board fpp_board_i (
		.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
		.ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in)
	);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	function automatic logic [31:0] z(input logic [4:0] v);
		return {27'h0, v};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one single word transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h000000, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
		chk(z({4'h0, hresp}), 32'h00000000);
		@(negedge hclk);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h00000000);
		chk(rd_q, exp);
	endtask

	task automatic t_reset;
		rd_chk(`FPP_IDX_DIR, 32'h00000000);
		rd_chk(`FPP_IDX_PULLUP, 32'h00000000);
		rd_chk(`FPP_IDX_LATCH_RMW, 32'h00000000);
		rd_chk(6'h06, 32'h00000000);
		chk(z(pin_oe), 32'h00000000);
	endtask

	task automatic t_output;
		xfer(1'b1, `FPP_IDX_DIR, 32'h000000ff);
		xfer(1'b1, `FPP_IDX_LATCH, 32'h000000fd);
		chk(z(pin_oe), 32'h0000001f);
		chk(z(pin_out & pin_oe), 32'h0000001d);
		rd_chk(`FPP_IDX_LATCH, 32'h0000001d);
		rd_chk(`FPP_IDX_DIR, 32'h0000001f);
		xfer(1'b1, `FPP_IDX_LATCH, 32'h00000002);
		chk(z(pin_oe), 32'h0000001d);
		chk(z(pin_out & pin_oe), 32'h00000000);
		rd_chk(`FPP_IDX_LATCH, 32'h00000002);
	endtask

	task automatic t_input;
		@(posedge hclk);
		ext_oe  <= 5'h1f;
		ext_val <= 5'h15;
		xfer(1'b1, `FPP_IDX_DIR, 32'h00000000);
		xfer(1'b1, `FPP_IDX_LATCH, 32'h0000000a);
		chk(z(pin_oe), 32'h00000000);
		rd_chk(`FPP_IDX_LATCH, 32'h00000015);
		rd_chk(`FPP_IDX_LATCH_RMW, 32'h0000000a);
		xfer(1'b1, `FPP_IDX_LATCH_RMW, 32'h0000001f);
		rd_chk(`FPP_IDX_LATCH_RMW, 32'h0000000a);
	endtask

	task automatic t_periph;
		@(posedge hclk);
		periph_oe  <= 5'h10;
		periph_out <= 5'h10;
		ext_oe     <= 5'h0f;
		ext_val    <= 5'h05;
		@(negedge hclk);
		chk(z(pin_oe & pin_out), 32'h00000010);
		chk(z(periph_in), 32'h00000015);
		rd_chk(`FPP_IDX_LATCH, 32'h00000015);
		rd_chk(`FPP_IDX_LATCH_RMW, 32'h0000000a);
		@(posedge hclk);
		periph_oe  <= 5'h00;
		periph_out <= 5'h00;
	endtask

	task automatic t_pull;
		xfer(1'b1, `FPP_IDX_PULLUP, 32'h0000001f);
		chk(z(pullup_en), 32'h0000001b);
		rd_chk(`FPP_IDX_PULLUP, 32'h0000001f);
		xfer(1'b1, `FPP_IDX_DIR, 32'h0000001f);
		chk(z(pullup_en), 32'h0000000a);
	endtask

	task automatic t_standby;
		@(posedge hclk);
		standby_req <= 1'b1;
		ext_oe      <= 5'h1f;
		ext_val     <= 5'h1f;
		@(negedge hclk);
		chk(z(pin_oe), 32'h0000001d);
		chk(z(pin_out & pin_oe), 32'h00000008);
		xfer(1'b1, `FPP_IDX_STANDBY, 32'h00000001);
		chk(z(pin_oe), 32'h00000000);
		chk(z(periph_in), 32'h00000000);
		rd_chk(`FPP_IDX_STANDBY, 32'h00000001);
		xfer(1'b1, `FPP_IDX_IRQ_CFG, 32'h00000007);
		chk(z(periph_in), 32'h00000009);
		xfer(1'b1, `FPP_IDX_IRQ_CFG, 32'h00000003);
		chk(z(periph_in), 32'h00000001);
		xfer(1'b1, `FPP_IDX_IRQ_CFG, 32'h00000005);
		chk(z(periph_in), 32'h00000008);
		rd_chk(`FPP_IDX_IRQ_CFG, 32'h00000005);
		@(posedge hclk);
		standby_req <= 1'b0;
		@(negedge hclk);
		chk(z(pin_oe), 32'h0000001d);
	endtask

	task automatic close_out;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			close_out();
		end
	end

	initial begin
		n_errors    = 0;
		checks      = 0;
		cycles      = 0;
		hresetn     = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h00000000;
		htrans      = 2'b00;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h00000000;
		standby_req = 1'b0;
		periph_oe   = 5'h00;
		periph_out  = 5'h00;
		ext_oe      = 5'h00;
		ext_val     = 5'h00;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_output();
		t_input();
		t_periph();
		t_pull();
		t_standby();
		close_out();
	end
endmodule
`default_nettype wire
